// ### hw/ebr_top.sv
// read strobe, upper data lines and port f sharing of the external bus
module ebr_top
    import ebr_pkg::*;
#(
    parameter int RD_LOW_CYCLES = RD_LOW_CYC
) (
    input wire logic clock_in,
    input wire logic resetn_in,
    input wire logic rd_req_in,
    input wire logic rd_space_in,
    input wire logic [ADDR_W-1:0] rd_addr_in,
    input wire logic [CS_W-1:0] rd_cs_in,
    output logic rd_ready_out,
    output logic rd_done_out,
    output logic [DATA_W-1:0] rd_data_out,
    input wire logic bus_idle_drive_select_in,
    input wire logic system_pullup_disable_ctrl_in,
    input wire logic [PORTF_W-1:0] port_f_pullup_control_in,
    input wire logic port_f_cfg_write_in,
    input wire logic [PORTF_W-1:0] port_f_periph_en_in,
    input wire logic [PORTF_W-1:0] port_f_dir_in,
    input wire logic [PORTF_W-1:0] port_f_data_in,
    output logic [PORTF_W-1:0] general_port_f_in_out,
    input wire logic [DATA_W-1:0] data_line_in,
    output logic [DATA_W-1:0] data_line_out,
    output logic [DATA_W-1:0] data_line_oe_out,
    output logic read_strobe_n_out,
    output logic read_strobe_oe_out,
    output logic read_strobe_pullup_en_out,
    output logic [PORTF_W-1:0] port_f_pullup_en_out,
    output logic [ADDR_W-1:0] external_address_lines_out,
    output logic external_address_oe_out,
    output logic [CS_W-1:0] chip_select_lines_n_out,
    output logic chip_select_oe_out,
    output logic program_space_select_n_out,
    output logic data_space_select_n_out
);
    // ------------------------------------------------------------
    // parameter checks
    // ------------------------------------------------------------
    if (RD_LOW_CYCLES < SYNC_MIN_CYC || RD_LOW_CYCLES > 255) begin : g_chk
        $error("read strobe width out of range");
    end

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic logic [DATA_W-1:0] widen_f(input logic [PORTF_W-1:0] v);
        widen_f = {v, {SHARED_LO{1'b0}}};
    endfunction

    // ------------------------------------------------------------
    // pad synchroniser
    // ------------------------------------------------------------
    ebr_pin_if #(.W(DATA_W)) bus_pins ();
    assign bus_pins.raw = data_line_in;
    ebr_sync #(.W(DATA_W)) u_sync (
        .clock_in(clock_in),
        .resetn_in(resetn_in),
        .pins(bus_pins)
    );

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    ebr_state_t state;
    ebr_state_t next_state;
    logic [7:0] cnt;
    logic [7:0] next_cnt;
    logic [ADDR_W-1:0] addr_q;
    logic [ADDR_W-1:0] next_addr_q;
    logic [CS_W-1:0] cs_q;
    logic [CS_W-1:0] next_cs_q;
    logic [DATA_W-1:0] next_rd_data;
    logic next_strobe_n;
    logic next_strobe_oe;
    logic next_addr_oe;
    logic [DATA_W-1:0] next_data_oe;
    logic [DATA_W-1:0] next_data_out;
    logic [PORTF_W-1:0] periph_en;
    logic [PORTF_W-1:0] next_periph_en;
    logic [PORTF_W-1:0] dir;
    logic [PORTF_W-1:0] next_dir;
    logic [PORTF_W-1:0] gpio_out;
    logic [PORTF_W-1:0] next_gpio_out;
    logic [DATA_W-1:0] gpio_mask;
    logic active;

    assign gpio_mask = widen_f(~periph_en);
    assign active = (next_state != ST_IDLE);

    // ------------------------------------------------------------
    // read cycle sequencer
    // ------------------------------------------------------------
    always_comb begin
        next_state = state;
        next_cnt = cnt;
        next_addr_q = addr_q;
        next_cs_q = cs_q;
        next_rd_data = rd_data_out;
        case (state)
            ST_IDLE: begin
                if (rd_req_in) begin
                    next_addr_q = rd_addr_in;
                    // cs0 is program space, cs1 data space
                    next_cs_q = rd_cs_in;
                    next_cs_q[CS_PROGRAM] = rd_cs_in[CS_PROGRAM] | !rd_space_in;
                    next_cs_q[CS_DATA] = rd_cs_in[CS_DATA] | rd_space_in;
                    next_state = ST_SETUP;
                end
            end
            ST_SETUP: begin
                next_cnt = 8'(RD_LOW_CYCLES - 1);
                next_state = ST_STROBE;
            end
            ST_STROBE: begin
                if (cnt == 8'h00) begin
                    // full sixteen bits taken as the strobe rises
                    next_rd_data = bus_pins.clean;
                    next_state = ST_HOLD;
                end else begin
                    next_cnt = cnt - 8'h01;
                end
            end
            ST_HOLD: begin
                next_state = ST_IDLE;
            end
            default: begin
                next_state = ST_IDLE;
            end
        endcase
    end

    // ------------------------------------------------------------
    // pin drive
    // ------------------------------------------------------------
    always_comb begin
        // strobe low only inside a read cycle
        next_strobe_n = (next_state != ST_STROBE);
        // idle strobe floats or drives by the select bit
        next_strobe_oe = active | bus_idle_drive_select_in;
        // address and selects driven across the whole cycle
        next_addr_oe = active | bus_idle_drive_select_in;
        // bus-function lines are inputs during a read, gpio lines follow dir
        next_data_oe = ({DATA_W{!active & bus_idle_drive_select_in}} & ~gpio_mask)
                     | (widen_f(dir) & gpio_mask);
        next_data_out = widen_f(gpio_out) & gpio_mask;
    end

    // ------------------------------------------------------------
    // port f configuration
    // ------------------------------------------------------------
    always_comb begin
        next_periph_en = periph_en;
        next_dir = dir;
        next_gpio_out = gpio_out;
        if (port_f_cfg_write_in) begin
            next_periph_en = port_f_periph_en_in;
            next_dir = port_f_dir_in;
            next_gpio_out = port_f_data_in;
        end
    end

    always_ff @(posedge clock_in) begin
        if (!resetn_in) begin
            state <= ST_IDLE;
            cnt <= 8'h00;
            addr_q <= '0;
            cs_q <= '0;
            rd_data_out <= '0;
            read_strobe_n_out <= 1'b1;
            read_strobe_oe_out <= 1'b0;
            external_address_oe_out <= 1'b0;
            data_line_oe_out <= '0;
            data_line_out <= '0;
            // shared pins come up on the data bus
            periph_en <= PERIPH_RST;
            dir <= DIR_RST;
            gpio_out <= '0;
            port_f_pullup_en_out <= PULLUP_RST;
            read_strobe_pullup_en_out <= 1'b1;
        end else begin
            state <= next_state;
            cnt <= next_cnt;
            addr_q <= next_addr_q;
            cs_q <= next_cs_q;
            rd_data_out <= next_rd_data;
            read_strobe_n_out <= next_strobe_n;
            read_strobe_oe_out <= next_strobe_oe;
            external_address_oe_out <= next_addr_oe;
            data_line_oe_out <= next_data_oe;
            data_line_out <= next_data_out;
            periph_en <= next_periph_en;
            dir <= next_dir;
            gpio_out <= next_gpio_out;
            // pull-up bit n cleared turns pin n pull-up off
            port_f_pullup_en_out <= port_f_pullup_control_in;
            // control bit set turns the strobe pull-up off
            read_strobe_pullup_en_out <= !system_pullup_disable_ctrl_in;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign rd_ready_out = (state == ST_IDLE);
    assign rd_done_out = (state == ST_HOLD);
    assign external_address_lines_out = addr_q;
    assign chip_select_lines_n_out = ~cs_q;
    assign chip_select_oe_out = external_address_oe_out;
    assign program_space_select_n_out = chip_select_lines_n_out[CS_PROGRAM];
    assign data_space_select_n_out = chip_select_lines_n_out[CS_DATA];
    assign general_port_f_in_out = bus_pins.clean[DATA_W-1:SHARED_LO];

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    logic [7:0] low_run;
    always_ff @(posedge clock_in) begin
        if (!resetn_in) begin
            low_run <= 8'h00;
        end else if (!read_strobe_n_out) begin
            low_run <= low_run + 8'h01;
        end else begin
            low_run <= 8'h00;
        end
    end

    default clocking cb @(posedge clock_in); endclocking
    default disable iff (!resetn_in);

    sequence s_req;
        rd_req_in && rd_ready_out;
    endsequence

    sequence s_strobe_start;
        read_strobe_n_out ##1 !read_strobe_n_out;
    endsequence

    sequence s_setup;
        read_strobe_n_out && !rd_ready_out && !rd_done_out;
    endsequence

    sequence s_hold;
        read_strobe_n_out && rd_done_out;
    endsequence

    sequence s_back_idle;
        read_strobe_n_out && rd_ready_out;
    endsequence

    strobe_cycle_a: assert property (s_req |=> s_strobe_start)
        else $error("strobe did not follow request");
    strobe_width_a: assert property ($rose(read_strobe_n_out) |-> low_run == 8'(RD_LOW_CYCLES))
        else $error("strobe low width wrong");
    strobe_only_read_a: assert property (!read_strobe_n_out |-> state == ST_STROBE)
        else $error("strobe low outside read");
    bus_input_a: assert property (!read_strobe_n_out |-> (data_line_oe_out & ~gpio_mask) == '0)
        else $error("data bus driven during read");
    capture_a: assert property ($rose(read_strobe_n_out) |-> rd_data_out == $past(bus_pins.clean))
        else $error("data not captured at strobe rise");
    addr_qual_a: assert property (!read_strobe_n_out |-> external_address_oe_out && chip_select_oe_out && $stable(external_address_lines_out))
        else $error("address not qualified");
    idle_drive_a: assert property ($past(state) == ST_IDLE && state == ST_IDLE |-> read_strobe_oe_out == $past(bus_idle_drive_select_in))
        else $error("idle strobe drive wrong");
    ps_select_a: assert property ((s_req and !rd_space_in) |=>
        ##1 !program_space_select_n_out[*2])
        else $error("program select not low");
    ds_select_a: assert property ((s_req and rd_space_in) |=>
        ##1 !data_space_select_n_out[*2])
        else $error("data select not low");
    pf_pullup_a: assert property ($past(resetn_in) |-> port_f_pullup_en_out == $past(port_f_pullup_control_in))
        else $error("port f pull-up mismatch");
    rd_pullup_a: assert property ($past(resetn_in) |-> read_strobe_pullup_en_out == !$past(system_pullup_disable_ctrl_in))
        else $error("strobe pull-up mismatch");
    reset_bus_a: assert property (!$past(resetn_in) |-> periph_en == PERIPH_RST)
        else $error("shared pins not on bus after reset");
    gpio_dir_a: assert property ($past(resetn_in) |-> (data_line_oe_out & gpio_mask) == (widen_f($past(dir)) & gpio_mask) || $past(port_f_cfg_write_in))
        else $error("gpio direction wrong");

    // ------------------------------------------------------------
    // read walk steps and idle behaviour
    // ------------------------------------------------------------
    setup_step_a: assert property (s_req |=> s_setup)
        else $error("no setup cycle before strobe");
    hold_step_a: assert property ($rose(read_strobe_n_out) |-> s_hold ##1 s_back_idle)
        else $error("no hold cycle after strobe");
    idle_strobe_a: assert property (rd_ready_out |-> read_strobe_n_out)
        else $error("strobe low while idle");
    strobe_count_a: assert property (state == ST_STROBE |-> cnt < 8'(RD_LOW_CYCLES))
        else $error("strobe counter out of range");
    strobe_drive_a: assert property (!read_strobe_n_out |-> read_strobe_oe_out)
        else $error("strobe not driven while low");
    space_select_a: assert property (!read_strobe_n_out |->
        !program_space_select_n_out || !data_space_select_n_out)
        else $error("no space select during read");
    reset_oe_a: assert property (!$past(resetn_in) |->
        data_line_oe_out == '0 && !read_strobe_oe_out)
        else $error("pins driven out of reset");
    pullup_reset_a: assert property (!$past(resetn_in) |->
        port_f_pullup_en_out == PULLUP_RST && read_strobe_pullup_en_out)
        else $error("pull-ups off out of reset");
    data_hold_a: assert property (rd_ready_out && $past(rd_ready_out) |->
        $stable(rd_data_out))
        else $error("read data changed while idle");
    addr_hold_a: assert property (!rd_ready_out && !$past(rd_ready_out) |->
        $stable(external_address_lines_out))
        else $error("address moved inside read");
    gpio_out_a: assert property ($past(resetn_in) && !$past(port_f_cfg_write_in) |->
        data_line_out == (widen_f($past(gpio_out)) & gpio_mask))
        else $error("gpio output value wrong");
endmodule

// ### hw/ebr_pkg.sv
// constants for the external bus read strobe and upper data lines
package ebr_pkg;
    // ------------------------------------------------------------
    // widths and layout
    // ------------------------------------------------------------
    localparam int ADDR_W = 17;
    localparam int DATA_W = 16;
    localparam int SHARED_LO = 7;
    localparam int PORTF_W = 9;
    localparam int CS_W = 4;
    localparam int CS_PROGRAM = 0;
    localparam int CS_DATA = 1;
    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic [PORTF_W-1:0] PERIPH_RST = 9'h1ff;
    localparam logic [PORTF_W-1:0] DIR_RST = 9'h000;
    localparam logic [PORTF_W-1:0] PULLUP_RST = 9'h1ff;
    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_PS = 8000;
    localparam int RD_LOW_NS = 32;
    localparam int RD_LOW_CYC = (RD_LOW_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int SYNC_MIN_CYC = 3;
    // ------------------------------------------------------------
    // states
    // ------------------------------------------------------------
    typedef enum logic [3:0] {
        ST_IDLE = 4'b0001,
        ST_SETUP = 4'b0010,
        ST_STROBE = 4'b0100,
        ST_HOLD = 4'b1000
    } ebr_state_t;
endpackage

// ### hw/ebr_pin_if.sv
// carrier between pad inputs and their synchroniser
interface ebr_pin_if #(parameter int W = 16);
    logic [W-1:0] raw;
    logic [W-1:0] clean;
    modport sync (input raw, output clean);
    modport user (output raw, input clean);
endinterface

// ### hw/ebr_sync.sv
// three stage pad synchroniser with agreement filter
module ebr_sync
    import ebr_pkg::*;
#(
    parameter int W = 16
) (
    input wire logic clock_in,
    input wire logic resetn_in,
    ebr_pin_if.sync pins
);
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] filt;
    logic [W-1:0] next_filt;

    // ------------------------------------------------------------
    // filter: take a bit once stages two and three agree
    // ------------------------------------------------------------
    always_comb begin
        next_filt = filt;
        for (int i = 0; i < W; i++) begin
            if (s2[i] == s3[i]) begin
                next_filt[i] = s3[i];
            end
        end
    end

    always_ff @(posedge clock_in) begin
        if (!resetn_in) begin
            s1 <= '0;
            s2 <= '0;
            s3 <= '0;
            filt <= '0;
        end else begin
            s1 <= pins.raw;
            s2 <= s1;
            s3 <= s2;
            filt <= next_filt;
        end
    end

    assign pins.clean = filt;
endmodule

// ### tb/ebr_sram_model.sv
// static memory model answering the read strobe on the far side of the bus
module ebr_sram_model
    import ebr_pkg::*;
(
    input wire logic clock_in,
    input wire logic slow_in,
    input wire logic read_strobe_n_in,
    input wire logic program_space_select_n_in,
    input wire logic data_space_select_n_in,
    input wire logic [ADDR_W-1:0] address_in,
    output logic [DATA_W-1:0] data_out,
    output logic data_oe_out
);
    timeunit 1ns;
    timeprecision 1ps;
    // ----
    // contents and drive
    // ----
    logic [DATA_W-1:0] content;
    logic [DATA_W-1:0] last = '0;
    int low_cnt = 0;
    logic sel;
    assign sel = !program_space_select_n_in || !data_space_select_n_in;
    assign content = address_in[15:0] ^ {15'h0, address_in[16]} ^ 16'h3c5a
        ^ (data_space_select_n_in ? 16'h0000 : 16'hff00);
    // slow answer: data appears one cycle into the strobe
    assign data_oe_out = !read_strobe_n_in && sel && (!slow_in || low_cnt >= 1);
    // released lines show the inverse of the last word
    assign data_out = data_oe_out ? content : ~last;
    always @(posedge clock_in) begin
        low_cnt <= read_strobe_n_in ? 0 : low_cnt + 1;
        if (data_oe_out) begin
            last <= content;
        end
    end
endmodule

// ### tb/ebr_top_bench.sv
// self-checking bench for the read strobe and upper data lines
`define CHK(what, exp, got) begin n_tests++; if ((got) !== (exp)) begin bad_count++; \
    $display("wrong value %s expected %h seen %h", what, exp, got); end end
module ebr_top_bench
    import ebr_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int RD_LOW = 6;
    logic clock_in, resetn_in, rd_req, rd_space, slow, drive_sel, pud, cfg_wr;
    logic [ADDR_W-1:0] rd_addr, addr_out;
    logic [CS_W-1:0] rd_cs, cs_n;
    logic [PORTF_W-1:0] pf_pull, per, dir, dat, pf_in, pf_pu, oe_e, out_e;
    logic [DATA_W-1:0] d_in, d_out, d_oe, m_data, last_exp, rd_data;
    logic m_oe, rd_ready, rd_done, strobe_n, strobe_oe, strobe_pu, addr_oe, cs_oe, ps_n, ds_n;
    int bad_count = 0;
    int n_tests = 0;
    // ----
    // design, memory and wire
    // ----
    assign d_in = (d_oe & d_out) | (~d_oe & m_data);
    ebr_top #(.RD_LOW_CYCLES(RD_LOW)) dut (.clock_in(clock_in), .resetn_in(resetn_in),
        .rd_req_in(rd_req), .rd_space_in(rd_space), .rd_addr_in(rd_addr), .rd_cs_in(rd_cs),
        .rd_ready_out(rd_ready), .rd_done_out(rd_done), .rd_data_out(rd_data),
        .bus_idle_drive_select_in(drive_sel), .system_pullup_disable_ctrl_in(pud),
        .port_f_pullup_control_in(pf_pull), .port_f_cfg_write_in(cfg_wr),
        .port_f_periph_en_in(per), .port_f_dir_in(dir), .port_f_data_in(dat),
        .general_port_f_in_out(pf_in), .data_line_in(d_in), .data_line_out(d_out),
        .data_line_oe_out(d_oe), .read_strobe_n_out(strobe_n), .read_strobe_oe_out(strobe_oe),
        .read_strobe_pullup_en_out(strobe_pu), .port_f_pullup_en_out(pf_pu),
        .external_address_lines_out(addr_out), .external_address_oe_out(addr_oe),
        .chip_select_lines_n_out(cs_n), .chip_select_oe_out(cs_oe),
        .program_space_select_n_out(ps_n), .data_space_select_n_out(ds_n));
    ebr_sram_model mem (.clock_in(clock_in), .slow_in(slow), .read_strobe_n_in(strobe_n),
        .program_space_select_n_in(ps_n), .data_space_select_n_in(ds_n),
        .address_in(addr_out), .data_out(m_data), .data_oe_out(m_oe));
    // ----
    // tasks
    // ----
    function automatic logic [DATA_W-1:0] mem_word(logic [ADDR_W-1:0] a, logic sp);
        return a[15:0] ^ {15'h0, a[16]} ^ 16'h3c5a ^ (sp ? 16'hff00 : 16'h0000);
    endfunction
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    // a second request in mid-read must be ignored
    task automatic do_read(input logic sp, input logic [ADDR_W-1:0] ad,
            input logic [CS_W-1:0] cs, input logic sl);
        int n;
        int lo;
        n = 0;
        lo = 0;
        while (rd_ready !== 1'b1) begin
            @(negedge clock_in);
        end
        slow = sl;
        rd_space = sp;
        rd_addr = ad;
        rd_cs = cs;
        rd_req = 1'b1;
        @(negedge clock_in);
        while (rd_done !== 1'b1 && n < 40) begin
            rd_req = (n == 1);
            if (n == 1) begin
                rd_addr = ~ad;
            end
            if (strobe_n === 1'b0) begin
                lo++;
                `CHK("data oe", 16'h0000, d_oe)
                `CHK("address", ad, addr_out)
                `CHK("chip selects", ~(cs | (sp ? 4'h2 : 4'h1)), cs_n)
                `CHK("program select", sp, ps_n)
                `CHK("data select", !sp, ds_n)
                `CHK("strobe oe", 1'b1, strobe_oe)
            end
            @(negedge clock_in);
            n++;
        end
        `CHK("done time", RD_LOW + 1, n)
        `CHK("ready in hold", 1'b0, rd_ready)
        `CHK("low time", RD_LOW, lo)
        `CHK("strobe high", 1'b1, strobe_n)
        last_exp = mem_word(ad, sp);
        `CHK("read data", last_exp, rd_data)
    endtask
    // ----
    // clock, watchdog, tests
    // ----
    initial begin
        clock_in = 1'b0;
        forever #4 clock_in = ~clock_in;
    end
    initial begin
        repeat (20000) @(posedge clock_in);
        bad_count++;
        tally_and_finish();
    end
    initial begin
        void'($urandom(32'h5d74));
        resetn_in = 1'b0;
        {rd_req, rd_space, slow, drive_sel, pud, cfg_wr} = '0;
        rd_addr = '0;
        rd_cs = '0;
        pf_pull = 9'h1ff;
        per = 9'h1ff;
        dir = '0;
        dat = '0;
        last_exp = '0;
        repeat (3) @(negedge clock_in);
        `CHK("strobe oe reset", 1'b0, strobe_oe)
        `CHK("strobe pullup reset", 1'b1, strobe_pu)
        `CHK("port f pullup reset", 9'h1ff, pf_pu)
        `CHK("data oe reset", 16'h0000, d_oe)
        resetn_in = 1'b1;
        @(negedge clock_in);
        for (int i = 0; i < 12; i++) begin
            do_read(1'($urandom_range(1)), ADDR_W'($urandom), {2'($urandom_range(3)), 2'b00},
                i[0]);
        end
        for (int k = 0; k < 2; k++) begin
            drive_sel = k[0];
            repeat (2) @(negedge clock_in);
            `CHK("idle strobe oe", k[0], strobe_oe)
            `CHK("idle bus oe", {9{k[0]}}, d_oe[15:7])
            `CHK("idle strobe", 1'b1, strobe_n)
        end
        for (int k = 0; k < 4; k++) begin
            pf_pull = PORTF_W'($urandom);
            pud = k[0];
            repeat (2) @(negedge clock_in);
            `CHK("port f pullup", pf_pull, pf_pu)
            `CHK("strobe pullup", !pud, strobe_pu)
        end
        for (int k = 0; k < 4; k++) begin
            per = PORTF_W'($urandom);
            dir = PORTF_W'($urandom);
            dat = PORTF_W'($urandom);
            cfg_wr = 1'b1;
            oe_e = (~per & dir) | per;
            out_e = ~per & dat;
            @(negedge clock_in);
            cfg_wr = 1'b0;
            repeat (8) @(negedge clock_in);
            `CHK("port f oe", oe_e, d_oe[15:7])
            `CHK("port f out", out_e, d_out[15:7])
            `CHK("port f level", (oe_e & out_e) | (~oe_e & ~last_exp[15:7]), pf_in)
        end
        per = 9'h1ff;
        cfg_wr = 1'b1;
        @(negedge clock_in);
        cfg_wr = 1'b0;
        repeat (2) @(negedge clock_in);
        do_read(1'b1, 17'h1a5f0, 4'h0, 1'b1);
        tally_and_finish();
    end
endmodule
